// >>> wks_pkg.sv
// Purpose: Constants for the wake-up event source status registers.
// Assumes: Eight-bit microcontroller data bus with a sixteen-bit address.
// Notes:   Register slots are indexed 0 to 5 in the order listed below.
package wks_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int WKS_NREG = 6;
  localparam int WKS_DW   = 8;
  localparam int WKS_AW   = 16;
  localparam int WKS_KSW  = 8;

  typedef logic [WKS_NREG-1:0][WKS_DW-1:0] wks_bank_t;

  // ----------------------------------------------------------------
  // Slot indexes
  // ----------------------------------------------------------------
  localparam int WKS_I_R2 = 0;
  localparam int WKS_I_R4 = 1;
  localparam int WKS_I_R5 = 2;
  localparam int WKS_I_R6 = 3;
  localparam int WKS_I_R7 = 4;
  localparam int WKS_I_R8 = 5;

  // ----------------------------------------------------------------
  // Addresses in the microcontroller memory map
  // ----------------------------------------------------------------
  localparam logic [WKS_AW-1:0] WKS_A_WAKE_SRC2          = 16'h7F2B;
  localparam logic [WKS_AW-1:0] WKS_A_STATUS_EDGE_GROUP0 = 16'h7F59;
  localparam logic [WKS_AW-1:0] WKS_A_STATUS_EDGE_GROUP1 = 16'h7F5E;
  localparam logic [WKS_AW-1:0] WKS_A_STATUS_EDGE_GROUP2 = 16'h7F63;
  localparam logic [WKS_AW-1:0] WKS_A_STATUS_MISC        = 16'h7F64;
  localparam logic [WKS_AW-1:0] WKS_A_STATUS_GPIO_SEC    = 16'h7F55;

  localparam logic [WKS_NREG-1:0][WKS_AW-1:0] WKS_ADDR = {
    WKS_A_STATUS_GPIO_SEC, WKS_A_STATUS_MISC, WKS_A_STATUS_EDGE_GROUP2,
    WKS_A_STATUS_EDGE_GROUP1, WKS_A_STATUS_EDGE_GROUP0, WKS_A_WAKE_SRC2};

  // ----------------------------------------------------------------
  // Implemented bits per register; all others are reserved
  // ----------------------------------------------------------------
  localparam logic [WKS_DW-1:0] WKS_V_R2 = 8'h06;
  localparam logic [WKS_DW-1:0] WKS_V_R4 = 8'hDC;
  localparam logic [WKS_DW-1:0] WKS_V_R5 = 8'hFF;
  localparam logic [WKS_DW-1:0] WKS_V_R6 = 8'hFF;
  localparam logic [WKS_DW-1:0] WKS_V_R7 = 8'h23;
  localparam logic [WKS_DW-1:0] WKS_V_R8 = 8'h0F;

  localparam wks_bank_t WKS_VALID = {
    WKS_V_R8, WKS_V_R7, WKS_V_R6, WKS_V_R5, WKS_V_R4, WKS_V_R2};

  // ----------------------------------------------------------------
  // Bit positions and reset values
  // ----------------------------------------------------------------
  localparam int WKS_B_ANYKEY = 1;
  localparam int WKS_B_HIB_ZERO = 2;
  localparam logic [WKS_DW-1:0] WKS_RST   = 8'h00;
  localparam logic [WKS_DW-1:0] WKS_ZERO  = 8'h00;
  localparam logic [WKS_KSW-1:0] WKS_KS_IDLE = 8'hFF;

endpackage

// >>> wks_regs.sv
// Purpose: Wake-up event source status registers with interrupt outputs.
// Assumes: Event inputs are synchronous to mclk; key scan pins are not.
// Notes:   Reads answer one cycle after the read strobe; masks are inputs.
`timescale 1ns/1ps

module wks_regs
(
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  // Microcontroller memory bus
  input  wire logic [wks_pkg::WKS_AW-1:0] mem_addr,
  input  wire logic                      mem_wr,
  input  wire logic                      mem_rd,
  input  wire logic [wks_pkg::WKS_DW-1:0] mem_wdata,
  output logic      [wks_pkg::WKS_DW-1:0] mem_rdata,
  // Wake events, one bit per register position except the key scan lines, which all feed one bit
  input  wire logic                      hibernation_countdown_zero,
  input  wire logic [wks_pkg::WKS_KSW-1:0] key_scan_input,
  input  wire logic [wks_pkg::WKS_DW-1:0] edge_wake_group0,
  input  wire logic [wks_pkg::WKS_DW-1:0] edge_wake_group1,
  input  wire logic [wks_pkg::WKS_DW-1:0] edge_wake_group2,
  input  wire logic                      serial_xfer_complete,
  input  wire logic                      fan_speed_pulse_1,
  input  wire logic                      fan_speed_pulse_2,
  input  wire logic [3:0]                secondary_io_wake,
  // Wake masks from the mask registers, one blocks the source
  input  wire wks_pkg::wks_bank_t         wake_mask,
  // Interrupt outputs, active low
  output logic                           ext_irq_line_1_n,
  output logic                           wake_irq_line_n
);
  import wks_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    wks_bank_t             stat;
    logic [WKS_KSW-1:0]    ks_meta;
    logic [WKS_KSW-1:0]    ks_sync;
    logic [WKS_DW-1:0]     rdata;
    logic                  irq1_n;
    logic                  irq5_n;
  } wks_state_t;

  wks_state_t s_q;
  wks_state_t s_d;
  wks_bank_t  ev;
  wks_bank_t  clr;
  logic       any_key_wake;
  logic       irq_pending;
  logic       addr_hit;

  // ----------------------------------------------------------------
  // Event assembly
  // ----------------------------------------------------------------
  always_comb begin
    // Key scan lines idle high; a single low line is a key press.
    any_key_wake = ~&s_q.ks_sync;
    ev = '0;
    ev[WKS_I_R2][WKS_B_HIB_ZERO] = hibernation_countdown_zero;
    ev[WKS_I_R2][WKS_B_ANYKEY] = any_key_wake;
    ev[WKS_I_R4] = edge_wake_group0 & WKS_V_R4;
    ev[WKS_I_R5] = edge_wake_group1 & WKS_V_R5;
    ev[WKS_I_R6] = edge_wake_group2 & WKS_V_R6;
    ev[WKS_I_R7] = {2'h0, serial_xfer_complete, 3'h0,
                    fan_speed_pulse_2, fan_speed_pulse_1};
    ev[WKS_I_R8] = {4'h0, secondary_io_wake};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    clr = '0;
    // Decoded once for all slots; a miss reads as zero and writes nothing.
    addr_hit = 1'b0;
    s_d.ks_meta = key_scan_input;
    s_d.ks_sync = s_q.ks_meta;
    for (int i = 0; i < WKS_NREG; i++) begin
      if (mem_addr == WKS_ADDR[i]) begin
        addr_hit = 1'b1;
      end
      if (mem_wr && mem_addr == WKS_ADDR[i]) begin
        clr[i] = mem_wdata & WKS_VALID[i];
      end
      // Set is applied after clear so a coincident event survives.
      s_d.stat[i] = ((s_q.stat[i] & ~clr[i]) | ev[i]) & WKS_VALID[i];
    end
    if (mem_rd) begin
      s_d.rdata = WKS_ZERO;
      for (int i = 0; i < WKS_NREG; i++) begin
        if (mem_addr == WKS_ADDR[i]) begin
          s_d.rdata = s_q.stat[i] & WKS_VALID[i];
        end
      end
    end
    // Both lines share one pending term so they never disagree.
    irq_pending = |(s_q.stat & ~wake_mask);
    s_d.irq1_n  = ~irq_pending;
    s_d.irq5_n  = ~irq_pending;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.stat    <= '0;
      s_q.ks_meta <= WKS_KS_IDLE;
      s_q.ks_sync <= WKS_KS_IDLE;
      s_q.rdata   <= WKS_RST;
      s_q.irq1_n  <= 1'b1;
      s_q.irq5_n  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_rdata        = s_q.rdata;
  assign ext_irq_line_1_n = s_q.irq1_n;
  assign wake_irq_line_n  = s_q.irq5_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_hib_timeout_sets: assert property (@(posedge mclk) disable iff (!reset_n)
    hibernation_countdown_zero |=> s_q.stat[WKS_I_R2][WKS_B_HIB_ZERO])
    else $error("hibernation bit not set");

  a_anykey_low: assert property (@(posedge mclk) disable iff (!reset_n)
    (key_scan_input != WKS_KS_IDLE) ##1 (key_scan_input != WKS_KS_IDLE)
    |=> ##1 s_q.stat[WKS_I_R2][WKS_B_ANYKEY])
    else $error("any-key bit not set after low scan input");

  a_anykey_wake: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_q.stat[WKS_I_R2][WKS_B_ANYKEY] && !wake_mask[WKS_I_R2][WKS_B_ANYKEY])
    |=> !wake_irq_line_n)
    else $error("unmasked any-key did not wake");

  a_w1c_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    (mem_wr && mem_addr == WKS_A_STATUS_EDGE_GROUP1 && ev[WKS_I_R5] == WKS_ZERO)
    |=> s_q.stat[WKS_I_R5] == ($past(s_q.stat[WKS_I_R5]) & ~$past(mem_wdata)))
    else $error("write-one clear wrong");

  a_read_value: assert property (@(posedge mclk) disable iff (!reset_n)
    (mem_rd && mem_addr == WKS_A_STATUS_MISC)
    |=> mem_rdata == $past(s_q.stat[WKS_I_R7]))
    else $error("read data does not show status");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_q.stat & ~WKS_VALID) == '0)
    else $error("reserved bit set");

  a_gpio_sets: assert property (@(posedge mclk) disable iff (!reset_n)
    secondary_io_wake[3] |=> s_q.stat[WKS_I_R8][3])
    else $error("secondary io bit not set");

  a_irq_or: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> (ext_irq_line_1_n == !$past(irq_pending))
      && (ext_irq_line_1_n == wake_irq_line_n))
    else $error("interrupt lines do not follow enabled status");

  a_mask_blocks: assert property (@(posedge mclk) disable iff (!reset_n)
    (wake_mask == '1) |=> ext_irq_line_1_n)
    else $error("masked source raised interrupt");

  a_set_wins: assert property (@(posedge mclk) disable iff (!reset_n)
    (mem_wr && mem_addr == WKS_A_STATUS_EDGE_GROUP2 && mem_wdata[0] && edge_wake_group2[0])
    |=> s_q.stat[WKS_I_R6][0])
    else $error("event lost to clear");

  // ----------------------------------------------------------------
  // Source placement, holding and unmapped reads
  // ----------------------------------------------------------------
  // A source wired to a reserved bit would be trimmed by the valid mask and lost.
  a_group0_sets: assert property (@(posedge mclk) disable iff (!reset_n)
    edge_wake_group0[7] |=> s_q.stat[WKS_I_R4][7])
    else $error("edge group 0 bit not set");

  a_group1_sets: assert property (@(posedge mclk) disable iff (!reset_n)
    edge_wake_group1[0] |=> s_q.stat[WKS_I_R5][0])
    else $error("edge group 1 bit not set");

  a_group2_sets: assert property (@(posedge mclk) disable iff (!reset_n)
    edge_wake_group2[7] |=> s_q.stat[WKS_I_R6][7])
    else $error("edge group 2 bit not set");

  a_serial_sets: assert property (@(posedge mclk) disable iff (!reset_n)
    serial_xfer_complete |=> s_q.stat[WKS_I_R7][5])
    else $error("serial completion bit not set");

  a_fan_sets: assert property (@(posedge mclk) disable iff (!reset_n)
    fan_speed_pulse_2 |=> s_q.stat[WKS_I_R7][1])
    else $error("fan speed bit not set");

  a_mask_keeps_status: assert property (@(posedge mclk) disable iff (!reset_n)
    (fan_speed_pulse_1 && wake_mask[WKS_I_R7][0])
    |=> s_q.stat[WKS_I_R7][0])
    else $error("masked source did not set status");

  a_status_holds: assert property (@(posedge mclk) disable iff (!reset_n)
    (!mem_wr && ev == '0) |=> $stable(s_q.stat))
    else $error("status changed without event or write");

  a_rdata_holds: assert property (@(posedge mclk) disable iff (!reset_n)
    !mem_rd |=> $stable(mem_rdata))
    else $error("read data changed without a read");

  a_unmapped_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    (mem_rd && !addr_hit) |=> mem_rdata == WKS_ZERO)
    else $error("unmapped read not zero");

endmodule

// >>> wks_mcu_model.sv
// Purpose: Microcontroller core model that reads and clears wake status.
// Assumes: Accesses begin after reset and use one-cycle strobes.
// Notes:   Requests change just after a rising edge by non-blocking assignment.
`timescale 1ns/1ps
module wks_mcu_model
  import wks_pkg::*;
(
  // Clock
  input  wire logic                       mclk,
  // Memory bus
  output logic      [wks_pkg::WKS_AW-1:0] mem_addr,
  output logic                            mem_wr,
  output logic                            mem_rd,
  output logic      [wks_pkg::WKS_DW-1:0] mem_wdata,
  input  wire logic [wks_pkg::WKS_DW-1:0] mem_rdata
);
  initial begin
    mem_addr  = 16'h0000;
    mem_wr    = 1'b0;
    mem_rd    = 1'b0;
    mem_wdata = 8'h00;
  end

  // Ones in the data ask for those status bits to be cleared.
  task automatic wr(input logic [WKS_AW-1:0] a, input logic [WKS_DW-1:0] d);
    @(posedge mclk);
    mem_addr  <= a;
    mem_wdata <= d;
    mem_wr    <= 1'b1;
    @(posedge mclk);
    mem_wr    <= 1'b0;
    // Stale data is inverted so a late sample cannot pass by luck.
    mem_wdata <= ~d;
  endtask

  task automatic rd(input logic [WKS_AW-1:0] a, output logic [WKS_DW-1:0] d);
    @(posedge mclk);
    mem_addr <= a;
    mem_rd   <= 1'b1;
    @(posedge mclk);
    mem_rd   <= 1'b0;
    #1;
    d = mem_rdata;
  endtask
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench for the wake-up event status registers.
// Assumes: Events are driven on the bus clock; key scan pins idle high.
// Notes:   Expected values come from the register layout, not the design.
`timescale 1ns/1ps
module testbench;
  import wks_pkg::*;
  logic              mclk, reset_n, mem_wr, mem_rd, hz, sxc, f1, f2, ext_n, wake_n;
  logic [WKS_AW-1:0] mem_addr;
  logic [WKS_DW-1:0] mem_wdata, mem_rdata, rv, g0, g1, g2, ks;
  logic [3:0]        io;
  wks_bank_t         mask;
  int                mismatches, num_checks;
  logic [7:0]        vm [6] = '{8'h06, 8'hDC, 8'hFF, 8'hFF, 8'h23, 8'h0F};

  wks_regs u_wks_regs (.mclk(mclk), .reset_n(reset_n), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .hibernation_countdown_zero(hz), .key_scan_input(ks), .edge_wake_group0(g0),
    .edge_wake_group1(g1), .edge_wake_group2(g2), .serial_xfer_complete(sxc),
    .fan_speed_pulse_1(f1), .fan_speed_pulse_2(f2), .secondary_io_wake(io),
    .wake_mask(mask), .ext_irq_line_1_n(ext_n), .wake_irq_line_n(wake_n));
  wks_mcu_model u_mcu (.mclk(mclk), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input int i, input logic [7:0] e);
    u_mcu.rd(WKS_ADDR[i], rv);
    chk($sformatf("slot %0d", i), e, rv);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // A hang is cut short here and counted as a mismatch.
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    stop_test();
  end

  initial begin
    {reset_n, hz, sxc, f1, f2, io, g0, g1, g2} = '0;
    ks = 8'hFF;
    mask = '0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < WKS_NREG; i++) rchk(i, 8'h00);
    @(posedge mclk);
    {hz, sxc, f1, f2, io, g0, g1, g2} <= '1;
    @(posedge mclk);
    {hz, sxc, f1, f2, io, g0, g1, g2} <= '0;
    repeat (2) @(posedge mclk);
    #1;
    chk("irq", 8'h00, {6'h00, ext_n, wake_n});
    u_mcu.wr(16'h7F5A, 8'hFF);
    u_mcu.rd(16'h7F5A, rv);
    chk("unmapped", 8'h00, rv);
    for (int i = 0; i < WKS_NREG; i++) begin
      rchk(i, i == 0 ? 8'h04 : vm[i]);
      u_mcu.wr(WKS_ADDR[i], 8'h5A);
      rchk(i, (i == 0 ? 8'h04 : vm[i]) & 8'hA5);
      u_mcu.wr(WKS_ADDR[i], 8'hFF);
      rchk(i, 8'h00);
    end
    chk("irq idle", 8'h03, {6'h00, ext_n, wake_n});
    @(posedge mclk);
    mask <= '1;
    f1 <= 1'b1;
    @(posedge mclk);
    f1 <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("irq masked", 8'h03, {6'h00, ext_n, wake_n});
    rchk(WKS_I_R7, 8'h01);
    @(posedge mclk);
    mask <= '0;
    repeat (2) @(posedge mclk);
    #1;
    chk("irq unmasked", 8'h00, {6'h00, ext_n, wake_n});
    u_mcu.wr(WKS_ADDR[WKS_I_R7], 8'h01);
    for (int k = 0; k < WKS_KSW; k++) begin
      @(posedge mclk);
      ks <= ~(8'h01 << k);
      repeat (4) @(posedge mclk);
      ks <= 8'hFF;
      rchk(WKS_I_R2, 8'h02);
      u_mcu.wr(WKS_ADDR[WKS_I_R2], 8'h02);
    end
    // The event lands on the very edge that takes the clearing write.
    fork
      u_mcu.wr(WKS_ADDR[WKS_I_R8], 8'h01);
      begin
        @(posedge mclk);
        io <= 4'h1;
        @(posedge mclk);
        io <= 4'h0;
      end
    join
    rchk(WKS_I_R8, 8'h01);
    fork
      u_mcu.wr(WKS_ADDR[WKS_I_R6], 8'h01);
      begin
        @(posedge mclk);
        g2 <= 8'h01;
        @(posedge mclk);
        g2 <= 8'h00;
      end
    join
    rchk(WKS_I_R6, 8'h01);
    stop_test();
  end
endmodule
